// ### rtl/ucf_regs.vh
// Register offsets, field positions, reset values and timing counts for the clock monitor
`ifndef UCF_REGS_VH
`define UCF_REGS_VH
`define UCF_OFF_CFG        12'h000
`define UCF_OFF_CTRL       12'h004
`define UCF_OFF_TUNE       12'h008
`define UCF_OFF_IRQ_EN     12'h00c
`define UCF_OFF_IRQ_FLAG   12'h010
`define UCF_OFF_CLKSEL     12'h014
`define UCF_OFF_STATUS     12'h018
`define UCF_CFG_TWO_SPEED_BIT 7
`define UCF_CFG_FCM_BIT    6
`define UCF_CFG_PLL_BIT    4
`define UCF_CTRL_RUN_BIT   3
`define UCF_TUNE_SPLL_BIT  6
`define UCF_IRQ_OSCF_BIT   7
`define UCF_CFG_RESET      8'h00
`define UCF_CTRL_RESET     8'h30
`define UCF_TUNE_RESET     8'h00
`define UCF_CLKSEL_RESET   8'h00
`define UCF_STARTUP_COUNT  11'd1024
`define UCF_SAMPLE_DIV     7'd64
`define UCF_SAMPLE_HALF    7'd32
`define UCF_MODE_LP        4'h0
`define UCF_MODE_XT        4'h1
`define UCF_MODE_HS        4'h2
`endif

// ### rtl/ucf_clock_failsafe.v
// Clock source selection, two-speed start-up and fail-safe clock monitor with APB registers
//
// Contract
// - Full speed: 48 MHz direct or 12 MHz times four; divider codes give 48/24/16/12
// - Low speed: USB divide 1 for 12 MHz, 0 for 6 MHz; system clock /1../4
// - USB derived system frequencies hold only when clock select is 00
// - With two-speed start-up, run from internal oscillator while start-up timer counts
// - LP/XT/HS without two-speed start-up halts code for 1024 oscillator cycles
// - Two-speed start-up switches back to primary oscillator when timer expires
// - Two-speed start-up acts after power-on, power-up timer and wake-up
// - Read-only status bit set on primary oscillator, clear on internal oscillator
// - Monitor enabled by its config bit, covers all external modes, after timer expiry
// - Sample clock is the low-frequency internal oscillator divided by 64
// - Detector latch set on external falling edge, cleared on sample rising edge
// - Failure when a full sample half-cycle passes without primary clock going low
// - On failure switch to internal source per frequency select and set fail flag
// - Interrupt request when fail flag and its enable are both set
// - After failure stay on internal source, never return on its own
// - Reset or toggling upper clock-select bit clears condition and restarts timer; in EC/RC modes the toggle does not clear the condition
// - When restarted timer expires, clear condition and switch to external source
// - Fail flag and fail condition are cleared independently
// - EC and RC modes skip the start-up timer; monitor active at once
// - Monitor enable forces two-speed start-up on
// - PLL on when config bit is 1, else follows software PLL enable
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "ucf_regs.vh"
module ucf_clock_failsafe (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Clock sources, sampled
   input  wire        ext_osc_clk,
   input  wire        lfint_osc_clk,
   // Power events
   input  wire        por_event,
   input  wire        power_up_timer_done,
   input  wire        wake_event,
   // Clock control outputs
   output reg         code_run,
   output reg         sys_from_primary,
   output reg  [2:0]  sys_internal_freq,
   output reg         pll_on,
   output reg  [1:0]  cpu_clk_divide_sel,
   output reg         usb_clk_divide_sel,
   output reg         usb_derived_clk,
   output reg         irq
);
   reg  [7:0]  cfg_reg;
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  tune_reg;
   reg  [7:0]  irq_en_reg;
   reg         osc_fail_flag_reg;
   reg  [7:0]  clksel_reg;
   reg  [2:0]  ext_sync_reg;
   reg  [2:0]  lf_sync_reg;
   reg  [5:0]  lf_div_reg;
   reg         sample_clk_reg;
   reg         sample_prev_reg;
   reg         detect_latch_reg;
   reg  [10:0] startup_cnt_reg;
   reg         startup_run_reg;
   reg         failsafe_reg;
   reg         sel_hi_prev_reg;
   wire        wr_en;
   wire        rd_en;
   wire        ext_fall;
   wire        lf_rise;
   wire        crystal_mode;
   wire        fcm_en;
   wire        two_speed_en;
   wire        startup_begin;
   wire        sel_hi_toggle;
   wire        sample_rise;
   wire        sample_fall;
   wire        fail_detect;
   wire [1:0]  sys_clk_select;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~pwrite;
   assign sys_clk_select = ctrl_reg[1:0];
   assign crystal_mode = (cfg_reg[3:0] == `UCF_MODE_LP) | (cfg_reg[3:0] == `UCF_MODE_XT)
                       | (cfg_reg[3:0] == `UCF_MODE_HS);
   assign fcm_en  = cfg_reg[`UCF_CFG_FCM_BIT];
   assign two_speed_en = cfg_reg[`UCF_CFG_TWO_SPEED_BIT] | fcm_en;
   assign sel_hi_toggle = ctrl_reg[1] ^ sel_hi_prev_reg;
   assign startup_begin = por_event | power_up_timer_done | wake_event
                        | (failsafe_reg & sel_hi_toggle);
   assign ext_fall = ext_sync_reg[2] & ~ext_sync_reg[1];
   assign lf_rise  = lf_sync_reg[1] & ~lf_sync_reg[2];
   assign sample_rise = sample_clk_reg & ~sample_prev_reg;
   assign sample_fall = ~sample_clk_reg & sample_prev_reg;
   // Latch still clear at the end of the high half: no external fall in a whole half-cycle
   assign fail_detect = fcm_en & ~startup_run_reg & ~failsafe_reg
                      & sample_fall & ~detect_latch_reg & ~ext_fall;

   // Synchronisers for the external and low-frequency clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync_reg <= 3'h0;
         lf_sync_reg  <= 3'h0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_osc_clk};
         lf_sync_reg  <= {lf_sync_reg[1:0], lfint_osc_clk};
      end
   end

   // Sample clock divider and fail detector
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_div_reg       <= 6'h00;
         sample_clk_reg   <= 1'b0;
         sample_prev_reg  <= 1'b0;
         detect_latch_reg <= 1'b0;
      end else begin
         if (lf_rise) begin
            lf_div_reg <= lf_div_reg + 6'h01;
            if (lf_div_reg == 6'h1f || lf_div_reg == 6'h3f)
               sample_clk_reg <= ~sample_clk_reg;
         end
         sample_prev_reg <= sample_clk_reg;
         if (ext_fall)
            detect_latch_reg <= 1'b1;
         else if (sample_rise)
            detect_latch_reg <= 1'b0;
      end
   end

   // Start-up timer and fail-safe condition
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         startup_cnt_reg <= 11'h000;
         startup_run_reg <= 1'b1;
         failsafe_reg    <= 1'b0;
         sel_hi_prev_reg <= 1'b0;
      end else begin
         sel_hi_prev_reg <= ctrl_reg[1];
         if (startup_begin) begin
            startup_cnt_reg <= 11'h000;
            startup_run_reg <= crystal_mode;
         end else if (startup_run_reg) begin
            // Expiry on the falling edge that completes the full count
            if (!crystal_mode
                || (ext_fall && startup_cnt_reg == `UCF_STARTUP_COUNT - 11'd1)) begin
               startup_run_reg <= 1'b0;
               failsafe_reg    <= 1'b0;
            end else if (ext_fall)
               startup_cnt_reg <= startup_cnt_reg + 11'h001;
         end
         if (fail_detect)
            failsafe_reg <= 1'b1;
      end
   end

   // Clock source and divider outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_run           <= 1'b0;
         sys_from_primary   <= 1'b0;
         sys_internal_freq  <= 3'h3;
         pll_on             <= 1'b0;
         cpu_clk_divide_sel <= 2'h0;
         usb_clk_divide_sel <= 1'b0;
         usb_derived_clk    <= 1'b0;
         irq                <= 1'b0;
      end else begin
         sys_from_primary  <= (sys_clk_select == 2'b00) & ~startup_run_reg
                              & ~failsafe_reg;
         code_run          <= ~startup_run_reg | two_speed_en | ~crystal_mode;
         sys_internal_freq <= ctrl_reg[6:4];
         pll_on <= cfg_reg[`UCF_CFG_PLL_BIT] | tune_reg[`UCF_TUNE_SPLL_BIT];
         cpu_clk_divide_sel <= clksel_reg[1:0];
         usb_clk_divide_sel <= clksel_reg[2];
         usb_derived_clk   <= (sys_clk_select == 2'b00);
         irq <= osc_fail_flag_reg & irq_en_reg[`UCF_IRQ_OSCF_BIT];
      end
   end

   // Register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg           <= `UCF_CFG_RESET;
         ctrl_reg          <= `UCF_CTRL_RESET;
         tune_reg          <= `UCF_TUNE_RESET;
         irq_en_reg        <= 8'h00;
         osc_fail_flag_reg <= 1'b0;
         clksel_reg        <= `UCF_CLKSEL_RESET;
      end else begin
         if (wr_en) begin
            case (paddr)
               `UCF_OFF_CFG:    cfg_reg    <= pwdata[7:0];
               `UCF_OFF_CTRL:   ctrl_reg   <= {pwdata[7:4], 1'b0, pwdata[2:0]};
               `UCF_OFF_TUNE:   tune_reg   <= pwdata[7:0];
               `UCF_OFF_IRQ_EN: irq_en_reg <= {pwdata[7:1], 1'b0};
               `UCF_OFF_CLKSEL: clksel_reg <= {5'h00, pwdata[2:0]};
               default: ;
            endcase
         end
         if (fail_detect)
            osc_fail_flag_reg <= 1'b1;
         else if (wr_en && paddr == `UCF_OFF_IRQ_FLAG && !pwdata[`UCF_IRQ_OSCF_BIT])
            osc_fail_flag_reg <= 1'b0;
      end
   end

   // Register reads
   always @* begin
      prdata = 32'h0;
      if (rd_en) begin
         case (paddr)
            `UCF_OFF_CFG:      prdata = {24'h0, cfg_reg};
            `UCF_OFF_CTRL:     prdata = {24'h0, ctrl_reg[7:4], sys_from_primary, 1'b1,
                                         ctrl_reg[1:0]};
            `UCF_OFF_TUNE:     prdata = {24'h0, tune_reg};
            `UCF_OFF_IRQ_EN:   prdata = {24'h0, irq_en_reg};
            `UCF_OFF_IRQ_FLAG: prdata = {24'h0, osc_fail_flag_reg, 7'h00};
            `UCF_OFF_CLKSEL:   prdata = {24'h0, clksel_reg};
            `UCF_OFF_STATUS:   prdata = {28'h0, code_run, failsafe_reg, startup_run_reg, pll_on};
            default:           prdata = 32'h0;
         endcase
      end
   end
endmodule // ucf_clock_failsafe

// ### verification/ucf_osc_model.sv
// External oscillator model that stops dead when disabled
`timescale 1ns/100ps
module ucf_osc_model #(
   parameter int HALF = 200
) (
   // Control and clock
   input  wire  run,
   output logic clk
);
   initial clk = 1'b0;
   // Falling edges come only while running; a failed part holds its level
   always #(HALF) if (run) clk = ~clk;
endmodule // ucf_osc_model

// ### verification/ucf_clock_failsafe_properties.sv
// Port level assertions for the clock monitor
`timescale 1ns/100ps
module ucf_clock_failsafe_properties (
   // APB side
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // Clock control
   input wire        sys_from_primary,
   input wire [2:0]  sys_internal_freq,
   input wire        pll_on,
   input wire [1:0]  cpu_clk_divide_sel,
   input wire        usb_clk_divide_sel,
   input wire        usb_derived_clk,
   input wire        irq,
   input wire        code_run
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire        wr = psel & penable & pwrite;
   reg  [31:0] wd_q;
   reg         en_q;
   // Last write data and the interrupt enable as software set it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_q <= 32'h0;
         en_q <= 1'b0;
      end else if (wr) begin
         wd_q <= pwdata;
         if (paddr == 12'h00c) en_q <= pwdata[7];
      end
   end
   AST_CPU_DIV: assert property (wr && paddr == 12'h014 |->
      ##[1:2] cpu_clk_divide_sel == wd_q[1:0]) else $error("cpu divide not applied");
   AST_USB_DIV: assert property (wr && paddr == 12'h014 |->
      ##[1:2] usb_clk_divide_sel == wd_q[2]) else $error("usb divide not applied");
   AST_USB_SRC: assert property (wr && paddr == 12'h004 |->
      ##[1:2] usb_derived_clk == (wd_q[1:0] == 2'b00)) else $error("usb source wrong");
   AST_INT_FREQ: assert property (wr && paddr == 12'h004 |->
      ##[1:2] sys_internal_freq == wd_q[6:4]) else $error("internal select wrong");
   AST_PLL_SOFT: assert property (wr && paddr == 12'h008 && pwdata[6] |->
      ##[1:2] pll_on) else $error("pll not on");
   AST_IRQ_EN: assert property ($rose(irq) |-> en_q) else $error("irq while masked");
   AST_IRQ_OFF: assert property (wr && paddr == 12'h00c && !pwdata[7] |->
      ##2 !irq) else $error("irq after mask");
   AST_STATUS_SRC: assert property (psel && penable && !pwrite && paddr == 12'h004 |->
      prdata[3] == sys_from_primary) else $error("status bit wrong");
   AST_RUN_PRIMARY: assert property (sys_from_primary |->
      code_run) else $error("primary clock but code halted");
   cover property ($fell(sys_from_primary));
   cover property ($rose(sys_from_primary));
   cover property ($rose(irq));
endmodule // ucf_clock_failsafe_properties
bind ucf_clock_failsafe ucf_clock_failsafe_properties i_ucf_clock_failsafe_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sys_from_primary(sys_from_primary),
   .sys_internal_freq(sys_internal_freq), .pll_on(pll_on), .irq(irq),
   .cpu_clk_divide_sel(cpu_clk_divide_sel), .usb_clk_divide_sel(usb_clk_divide_sel),
   .usb_derived_clk(usb_derived_clk), .code_run(code_run));

// ### verification/tb_ucf_clock_failsafe.sv
// Self-checking bench for the clock monitor
`timescale 1ns/100ps
module tb_ucf_clock_failsafe;
   typedef struct {logic [11:0] a; logic [31:0] d, m, e;} ucf_row_t;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        lfint_osc_clk = 1'b0, osc_run = 1'b1, ext_osc_clk, rdy, err;
   logic [2:0]  evt = 3'h0;
   logic        pready, pslverr, code_run, sys_from_primary, pll_on, usb_clk_divide_sel;
   logic        usb_derived_clk, irq;
   logic [2:0]  sys_internal_freq;
   logic [1:0]  cpu_clk_divide_sel;
   int          failures = 0, checks = 0;
   ucf_row_t    rows [7] = '{'{12'h014, 32'hffffff04, 32'hffffffff, 32'h4},
      '{12'h014, 32'h1, 32'hffffffff, 32'h1}, '{12'h014, 32'h2, 32'hffffffff, 32'h2},
      '{12'h014, 32'h3, 32'hffffffff, 32'h3}, '{12'h008, 32'h40, 32'hffffffff, 32'h40},
      '{12'h004, 32'h51, 32'h73, 32'h51}, '{12'h100, 32'hff, 32'hffffffff, 32'h0}};
   always #20 pclk = ~pclk;
   always #400 lfint_osc_clk = ~lfint_osc_clk;
   ucf_osc_model i_ucf_osc_model (.run(osc_run), .clk(ext_osc_clk));
   ucf_clock_failsafe i_ucf_clock_failsafe (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ext_osc_clk(ext_osc_clk), .por_event(evt[0]),
      .lfint_osc_clk(lfint_osc_clk), .power_up_timer_done(evt[1]), .wake_event(evt[2]),
      .code_run(code_run), .sys_from_primary(sys_from_primary), .pll_on(pll_on),
      .sys_internal_freq(sys_internal_freq), .cpu_clk_divide_sel(cpu_clk_divide_sel),
      .usb_clk_divide_sel(usb_clk_divide_sel), .usb_derived_clk(usb_derived_clk), .irq(irq));
   task end_of_test;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(negedge pclk);
         rdy = pready;
         err = pslverr;
         r = prdata;
         @(posedge pclk);
         k++;
      end while (rdy !== 1'b1 && k < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      chk({30'b0, k == 50, err}, 32'h0);
      if (k == 50) end_of_test;
   endtask
   task wait_prim(input logic v, input int n);
      int k;
      k = 0;
      while (sys_from_primary !== v && k < n) begin
         @(negedge pclk);
         k++;
      end
      chk({31'b0, sys_from_primary}, {31'b0, v});
      if (sys_from_primary !== v) end_of_test;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({29'b0, sys_internal_freq}, 32'h3);
      for (int i = 0; i < 7; i++) begin
         xfer(1'b0, 12'(i * 4), 32'h0, q);
         chk(q, (i == 1) ? 32'h34 : (i == 6) ? 32'h2 : 32'h0);
      end
      chk({31'b0, code_run}, 32'h0);
      foreach (rows[i]) begin
         xfer(1'b1, rows[i].a, rows[i].d, q);
         xfer(1'b0, rows[i].a, 32'h0, q);
         chk(q & rows[i].m, rows[i].e);
         if (rows[i].a == 12'h014) begin
            chk({30'b0, cpu_clk_divide_sel}, {30'b0, rows[i].d[1:0]});
            chk({31'b0, usb_clk_divide_sel}, {31'b0, rows[i].d[2]});
         end
      end
      xfer(1'b1, 12'h004, 32'h60, q);
      xfer(1'b1, 12'h000, 32'h41, q);
      repeat (2) @(negedge pclk);
      chk({31'b0, code_run}, 32'h1);
      chk({31'b0, sys_from_primary}, 32'h0);
      wait_prim(1'b1, 20000);
      xfer(1'b0, 12'h004, 32'h0, q);
      chk(q & 32'h8, 32'h8);
      xfer(1'b1, 12'h00c, 32'h80, q);
      osc_run <= 1'b0;
      wait_prim(1'b0, 4000);
      xfer(1'b0, 12'h010, 32'h0, q);
      chk(q, 32'h80);
      chk({31'b0, irq}, 32'h1);
      chk({29'b0, sys_internal_freq}, 32'h6);
      xfer(1'b1, 12'h00c, 32'h0, q);
      repeat (2) @(negedge pclk);
      chk({31'b0, irq}, 32'h0);
      xfer(1'b1, 12'h00c, 32'h80, q);
      repeat (2) @(negedge pclk);
      chk({31'b0, irq}, 32'h1);
      @(posedge pclk);
      osc_run <= 1'b1;
      repeat (3000) @(posedge pclk);
      chk({31'b0, sys_from_primary}, 32'h0);
      xfer(1'b1, 12'h010, 32'h0, q);
      xfer(1'b0, 12'h010, 32'h0, q);
      chk(q, 32'h0);
      chk({31'b0, irq}, 32'h0);
      xfer(1'b1, 12'h004, 32'h62, q);
      xfer(1'b1, 12'h004, 32'h60, q);
      wait_prim(1'b1, 20000);
      for (int j = 0; j < 3; j++) begin
         @(posedge pclk);
         evt <= 3'(1 << j);
         @(posedge pclk);
         evt <= 3'h0;
         wait_prim(1'b0, 20);
         wait_prim(1'b1, 20000);
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      chk({31'b0, sys_from_primary}, 32'h0);
      chk({31'b0, code_run}, 32'h0);
      end_of_test;
   end
endmodule // tb_ucf_clock_failsafe
